// >>> pkg/lsx_map.svh
// register map, field positions, reset values and timing figures of the
// indicator select and pair crossover register group
// assumes a 50 MHz ref_clk and a 32-bit classic Wishbone slave port
// ****************************************************************
// ****************************************************************
`ifndef LSX_MAP_SVH
`define LSX_MAP_SVH
// register indexes; byte address is four times the index
`define LSX_IDX_RSV_A 5'h14
`define LSX_IDX_RSV_B 5'h15
`define LSX_IDX_RSV_C 5'h16
`define LSX_IDX_IND_CFG 5'h17
`define LSX_IDX_XOVER 5'h18
// indicator config fields
`define LSX_IND_B_MSB 7
`define LSX_IND_B_LSB 4
`define LSX_IND_A_MSB 3
`define LSX_IND_A_LSB 0
`define LSX_IND_B_RST 4'h1
`define LSX_IND_A_RST 4'h0
// crossover control fields
`define LSX_XO_ASSIST 7
`define LSX_XO_AUTO 6
`define LSX_XO_PAIR 5
`define LSX_XO_DONE 4
`define LSX_XO_SEED_MSB 3
`define LSX_XO_SEED_LSB 0
`define LSX_XO_AUTO_RST 1'h1
`define LSX_XO_ASSIST_RST 1'h0
`define LSX_XO_PAIR_RST 1'h0
`define LSX_XO_SEED_RST 4'h0
`define LSX_XO_SEED_INT 4'h5
// timing
`define LSX_CLK_KHZ 50000
`define LSX_TRY_US 1000
`define LSX_BLINK_MS 40
`endif

// >>> pkg/lsx_pkg.sv
// types of the indicator select and pair crossover register group
// assumes lsx_map.svh is compiled alongside
package lsx_pkg;
   // line status inputs from the transceiver core
   typedef struct packed {
      logic linkGood;
      logic txAct;
      logic rxAct;
      logic collision;
      logic speed100;
      logic fullDuplex;
      logic localAnegOn;
      logic lineEnergy;
   } lsx_status_t;
   typedef enum logic [1:0] {XO_IDLE, XO_SEEK, XO_DONE} lsx_xo_state_t;
endpackage : lsx_pkg

// >>> rtl/lsx_ctrl.sv
// indicator source select and automatic pair crossover register group
// assumes status comes from pins or other clocks, so it is synchronised;
// software reaches the registers as a classic Wishbone slave
`include "lsx_map.svh"
module lsx_ctrl #(
   parameter int TRY_CYC = (`LSX_TRY_US * `LSX_CLK_KHZ) / 1000,
   parameter int BLINK_CYC = `LSX_BLINK_MS * `LSX_CLK_KHZ
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire lsx_pkg::lsx_status_t lineStatus,
   output logic indicatorA,
   output logic indicatorB,
   output logic pairAssignment,
   output logic crossoverDone
);
   import lsx_pkg::*;

   // ****************************************************************
   // status synchroniser
   // ****************************************************************
   lsx_status_t syncA, syncB, syncC, stat;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         syncA <= '0;
         syncB <= '0;
         syncC <= '0;
         stat <= '0;
      end else begin
         syncA <= lineStatus;
         syncB <= syncA;
         syncC <= syncB;
         for (int i = 0; i < $bits(lsx_status_t); i++) begin
            if (syncB[i] == syncC[i]) begin
               stat[i] <= syncC[i];
            end
         end
      end
   end

   // ****************************************************************
   // register bus
   // ****************************************************************
   logic [3:0] indicator_b_select, indicator_a_select;
   logic parallel_detect_assist, crossover_auto_enable;
   logic [3:0] crossover_seed;
   wire [4:0] regIdx = wb_adr_i[6:2];
   wire busReq = wb_cyc_i & wb_stb_i;
   wire wrNow = busReq & wb_we_i & wb_ack_o & wb_sel_i[0];
   wire selCfg = (regIdx == `LSX_IDX_IND_CFG) & ~wb_adr_i[7];
   wire selXo = (regIdx == `LSX_IDX_XOVER) & ~wb_adr_i[7];
   wire wrCfg = wrNow & selCfg;
   wire wrXo = wrNow & selXo;
   wire [15:0] cfgWord = {8'h00, indicator_b_select, indicator_a_select};
   wire [15:0] xoWord = {8'h00, parallel_detect_assist, crossover_auto_enable,
                         pairAssignment, crossoverDone, crossover_seed};
   // reserved registers and unmapped addresses read zero
   wire [31:0] readData = selCfg ? {16'h0000, cfgWord} :
                          selXo ? {16'h0000, xoWord} : 32'h0000_0000;

   // one wait state: ack follows the request by one edge, writes land on the ack edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= busReq & ~wb_ack_o;
         if (busReq & ~wb_ack_o) begin
            wb_dat_o <= readData;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         indicator_b_select <= `LSX_IND_B_RST;
         indicator_a_select <= `LSX_IND_A_RST;
         parallel_detect_assist <= `LSX_XO_ASSIST_RST;
         crossover_auto_enable <= `LSX_XO_AUTO_RST;
         crossover_seed <= `LSX_XO_SEED_RST;
      end else begin
         if (wrCfg) begin
            indicator_b_select <= wb_dat_i[`LSX_IND_B_MSB:`LSX_IND_B_LSB];
            indicator_a_select <= wb_dat_i[`LSX_IND_A_MSB:`LSX_IND_A_LSB];
         end
         if (wrXo) begin
            parallel_detect_assist <= wb_dat_i[`LSX_XO_ASSIST];
            crossover_auto_enable <= wb_dat_i[`LSX_XO_AUTO];
            crossover_seed <= wb_dat_i[`LSX_XO_SEED_MSB:`LSX_XO_SEED_LSB];
         end
      end
   end

   // ****************************************************************
   // indicator sources
   // ****************************************************************
   logic [$clog2(BLINK_CYC)-1:0] blinkCnt;
   logic blinkPhase;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         blinkCnt <= '0;
         blinkPhase <= 1'b0;
      end else if (blinkCnt == $bits(blinkCnt)'(BLINK_CYC - 1)) begin
         blinkCnt <= '0;
         blinkPhase <= ~blinkPhase;
      end else begin
         blinkCnt <= blinkCnt + 1'b1;
      end
   end

   function automatic logic ind_source(input logic [3:0] code, input lsx_status_t s, input logic blink);
      logic anyAct;
      anyAct = s.txAct | s.rxAct;
      unique case (code)
         4'h0: ind_source = s.linkGood;
         4'h1: ind_source = anyAct;
         4'h2: ind_source = s.txAct;
         4'h3: ind_source = s.rxAct;
         4'h4: ind_source = s.collision;
         4'h5: ind_source = s.speed100;
         4'h6: ind_source = ~s.speed100 & s.linkGood;
         4'h7: ind_source = s.fullDuplex;
         4'h8: ind_source = s.linkGood & ~(anyAct & blink);
         default: ind_source = 1'b0;
      endcase
   endfunction : ind_source

   wire next_indicatorA = ind_source(indicator_a_select, stat, blinkPhase);
   wire next_indicatorB = ind_source(indicator_b_select, stat, blinkPhase);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         indicatorA <= 1'b0;
         indicatorB <= 1'b0;
      end else begin
         indicatorA <= next_indicatorA;
         indicatorB <= next_indicatorB;
      end
   end

   // ****************************************************************
   // automatic crossover
   // ****************************************************************
   lsx_xo_state_t xoState;
   logic [3:0] pattern;
   logic [$clog2(TRY_CYC)-1:0] tryCnt;
   // switching runs with local negotiation, or through the assist bit
   wire xoRun = crossover_auto_enable & (stat.localAnegOn | parallel_detect_assist);
   wire tryEnd = (tryCnt == $bits(tryCnt)'(TRY_CYC - 1));
   wire [3:0] seedUsed = (crossover_seed == 4'h0) ? `LSX_XO_SEED_INT : crossover_seed;
   wire [3:0] next_pattern = {pattern[2:0], pattern[3] ^ pattern[2]};
   wire seedLoad = xoRun & (xoState == XO_IDLE);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         xoState <= XO_IDLE;
         pattern <= `LSX_XO_SEED_INT;
         tryCnt <= '0;
      end else if (!xoRun) begin
         xoState <= XO_IDLE;
         tryCnt <= '0;
      end else begin
         unique case (xoState)
            XO_IDLE: begin
               pattern <= seedUsed;
               tryCnt <= '0;
               xoState <= XO_SEEK;
            end
            XO_SEEK: begin
               if (stat.lineEnergy) begin
                  xoState <= XO_DONE;
               end else if (tryEnd) begin
                  pattern <= next_pattern;
                  tryCnt <= '0;
               end else begin
                  tryCnt <= tryCnt + 1'b1;
               end
            end
            XO_DONE: begin
               if (!stat.lineEnergy) begin
                  xoState <= XO_SEEK;
                  tryCnt <= '0;
               end
            end
         endcase
      end
   end

   // pair follows the pattern while auto, else software forces it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pairAssignment <= `LSX_XO_PAIR_RST;
      end else if (crossover_auto_enable) begin
         if (xoRun && xoState == XO_IDLE) begin
            pairAssignment <= seedUsed[0];
         end else if (xoRun && xoState == XO_SEEK && !stat.lineEnergy && tryEnd) begin
            pairAssignment <= next_pattern[0];
         end
      end else if (wrXo) begin
         pairAssignment <= wb_dat_i[`LSX_XO_PAIR];
      end
   end

   assign crossoverDone = crossover_auto_enable & (xoState == XO_DONE);

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_IND_B_RESET: assert property ($past(rst) |-> indicator_b_select == 4'h1)
      else $error("second selector not 0001 after reset");
   AST_IND_A_RESET: assert property ($past(rst) |-> indicator_a_select == 4'h0)
      else $error("first selector not 0000 after reset");
   AST_DECODE_COL: assert property (indicator_a_select == 4'h4 && $stable(indicator_a_select)
      |=> indicatorA == $past(stat.collision))
      else $error("collision code does not show collision");
   AST_DECODE_ACT: assert property (indicator_b_select == 4'h1 && $stable(indicator_b_select)
      |=> indicatorB == $past(stat.txAct | stat.rxAct))
      else $error("activity code does not show activity");
   AST_NO_ASSIST: assert property (crossover_auto_enable && !stat.localAnegOn && !parallel_detect_assist
      |=> xoState == XO_IDLE)
      else $error("switching ran without negotiation or assist");
   AST_AUTO_RESET: assert property ($past(rst) |-> crossover_auto_enable && !pairAssignment)
      else $error("crossover reset values wrong");
   AST_PAIR_HOLD: assert property (crossover_auto_enable && xoState == XO_DONE && xoRun
      && stat.lineEnergy |=> $stable(pairAssignment))
      else $error("pair changed after completion");
   AST_PAIR_FORCE: assert property (!crossover_auto_enable && wrXo && !wb_dat_i[`LSX_XO_AUTO]
      |=> pairAssignment == $past(wb_dat_i[`LSX_XO_PAIR]))
      else $error("forced pair not taken");
   AST_DONE_OFF: assert property (!crossover_auto_enable |-> !crossoverDone)
      else $error("done set while auto disabled");
   AST_SEED_LOAD: assert property (seedLoad |=> pattern == $past(seedUsed) && pattern != 4'h0)
      else $error("seed not loaded");
   AST_SEED_ZERO: assert property (seedLoad && crossover_seed == 4'h0 |=> pattern == 4'h5)
      else $error("zero seed not replaced by 0101");
   AST_RSVD_ZERO: assert property (busReq && !wb_ack_o && (selCfg || selXo)
      |=> wb_ack_o ##0 wb_dat_o[31:8] == 24'h000000)
      else $error("reserved bits read nonzero");

   COV_CFG_WRITE: cover property (wrCfg);
   COV_XO_DONE: cover property (xoState == XO_SEEK ##1 xoState == XO_DONE);
   COV_FORCE: cover property (!crossover_auto_enable && wrXo);
   COV_ASSIST: cover property (xoRun && !stat.localAnegOn);
endmodule : lsx_ctrl

// >>> bench/lsx_link_partner.sv
// far end of the cable: raises line energy once the local pair matches its own
// assumes it shares ref_clk with the register group; slow stretches settling
module lsx_link_partner (
   input wire logic ref_clk,
   input wire logic present,
   input wire logic slow,
   input wire logic wantPair,
   input wire logic pairAssignment,
   output logic lineEnergy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] settle = 5'h00;
   wire match = present && (pairAssignment == wantPair);
   always_ff @(posedge ref_clk) begin
      settle <= match ? ((settle == 5'h1F) ? settle : settle + 5'h01) : 5'h00;
      lineEnergy <= match && (settle >= (slow ? 5'h14 : 5'h02));
   end
endmodule : lsx_link_partner

// >>> bench/test_led_select_and_crossover_ctrl.sv
// self-checking bench for the indicator select and crossover register group
// assumes lsx_pkg, lsx_map.svh, lsx_ctrl and lsx_link_partner are compiled first
module test_led_select_and_crossover_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import lsx_pkg::*;
   logic refClk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0000_0000, wbDatO, rdData;
   logic wbAck, indA, indB, pairAsg, xoDone, energy;
   logic present = 1'b0, slow = 1'b0, wantPair = 1'b0;
   lsx_status_t st = '0;
   lsx_status_t lineStat;
   int miscompares = 0, checksDone = 0, cycles = 0;
   assign lineStat = {st[7:1], energy};
   always #10 refClk = ~refClk;
   lsx_ctrl #(.TRY_CYC(16), .BLINK_CYC(4)) uut (.ref_clk(refClk), .rst(rst), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .lineStatus(lineStat), .indicatorA(indA),
      .indicatorB(indB), .pairAssignment(pairAsg), .crossoverDone(xoDone));
   lsx_link_partner partner (.ref_clk(refClk), .present(present), .slow(slow), .wantPair(wantPair),
      .pairAssignment(pairAsg), .lineEnergy(energy));
   // ****************
   // bus and compare tasks
   // ****************
   task automatic results;
      $display("checks %0d, mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chkw
   task automatic chkb(input logic got, input logic exp);
      checksDone++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chkb
   task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= sel;
      wbDatI <= dat;
      do @(posedge refClk); while (wbAck !== 1'b1);
      rdData = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge refClk);
   endtask : wbXfer
   task automatic wbw(input logic [7:0] adr, input logic [31:0] dat);
      wbXfer(1'b1, adr, dat, 4'hF);
   endtask : wbw
   task automatic wbr(input logic [7:0] adr, input logic [31:0] exp);
      wbXfer(1'b0, adr, 32'h0000_0000, 4'hF);
      chkw(rdData, exp);
   endtask : wbr
   task automatic idle(input int n);
      repeat (n) @(posedge refClk);
   endtask : idle
   task automatic waitDone(input logic exp, input int lim);
      int n;
      n = 0;
      while (xoDone !== exp && n < lim) begin
         @(posedge refClk);
         n++;
      end
      chkb(xoDone, exp);
   endtask : waitDone
   function automatic logic expInd(input logic [3:0] c, input lsx_status_t s);
      case (c)
         4'h0: return s.linkGood;
         4'h1: return s.txAct | s.rxAct;
         4'h2: return s.txAct;
         4'h3: return s.rxAct;
         4'h4: return s.collision;
         4'h5: return s.speed100;
         4'h6: return s.linkGood & ~s.speed100;
         4'h7: return s.fullDuplex;
         4'h8: return s.linkGood;
         default: return 1'b0;
      endcase
   endfunction : expInd
   // blinking source: level while the line is quiet, toggling while active with the link good, low while active with the link down
   task automatic indPass(input lsx_status_t s);
      logic quiet, seenLo, seenHi;
      quiet = !(s.txAct || s.rxAct);
      st <= s;
      for (int c = 0; c < 10; c++) begin
         wbw(8'h5C, {24'h00_0000, 4'(9 - c), 4'(c)});
         idle(6);
         if (c != 8 || quiet) chkb(indA, expInd(4'(c), s));
         if (c != 1 || quiet) chkb(indB, expInd(4'(9 - c), s));
         if (c == 8 && !quiet) begin
            seenLo = 1'b0;
            seenHi = 1'b0;
            repeat (8) begin
               @(posedge refClk);
               seenLo |= ~indA;
               seenHi |= indA;
            end
            chkb(seenLo & seenHi, s.linkGood);
         end
      end
   endtask : indPass
   always @(posedge refClk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         results();
      end
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (5) @(posedge refClk);
      rst <= 1'b0;
      @(posedge refClk);
      wbr(8'h5C, 32'h0000_0010);
      wbr(8'h60, 32'h0000_0040);
      wbw(8'h50, 32'h0000_0000);
      wbr(8'h50, 32'h0000_0000);
      wbr(8'h58, 32'h0000_0000);
      wbr(8'h80, 32'h0000_0000);
      wbw(8'h5C, 32'h0000_0032);
      wbr(8'h5C, 32'h0000_0032);
      wbXfer(1'b1, 8'h5C, 32'h0000_0077, 4'hE);
      wbr(8'h5C, 32'h0000_0032);
      wbw(8'h60, 32'h0000_FF40);
      wbr(8'h60, 32'h0000_0040);
      indPass(lsx_status_t'(8'hC8));
      indPass(lsx_status_t'(8'h94));
      present <= 1'b1;
      wantPair <= 1'b1;
      st <= lsx_status_t'(8'h02);
      waitDone(1'b1, 24);
      chkb(pairAsg, 1'b1);
      wbr(8'h60, 32'h0000_0070);
      wbw(8'h60, 32'h0000_0040);
      idle(2);
      chkb(pairAsg, 1'b1);
      st <= '0;
      waitDone(1'b0, 24);
      wbw(8'h60, 32'h0000_0042);
      wantPair <= 1'b0;
      st <= lsx_status_t'(8'h02);
      waitDone(1'b1, 24);
      chkb(pairAsg, 1'b0);
      present <= 1'b0;
      waitDone(1'b0, 24);
      st <= '0;
      wantPair <= 1'b1;
      present <= 1'b1;
      slow <= 1'b1;
      idle(30);
      chkb(xoDone, 1'b0);
      wbw(8'h60, 32'h0000_00C0);
      waitDone(1'b1, 60);
      wbw(8'h60, 32'h0000_0001);
      wantPair <= 1'b0;
      slow <= 1'b0;
      // let the old line energy drain through the synchroniser
      idle(8);
      chkb(xoDone, 1'b0);
      wbw(8'h60, 32'h0000_00C1);
      waitDone(1'b1, 60);
      chkb(pairAsg, 1'b0);
      wbw(8'h60, 32'h0000_0020);
      idle(2);
      chkb(pairAsg, 1'b0);
      chkb(xoDone, 1'b0);
      wbw(8'h60, 32'h0000_0020);
      idle(2);
      chkb(pairAsg, 1'b1);
      wbr(8'h60, 32'h0000_0020);
      wbw(8'h60, 32'h0000_0000);
      wbr(8'h60, 32'h0000_0000);
      results();
   end
endmodule : test_led_select_and_crossover_ctrl
